// [verilog/dfbm_consts.svh]
// dfbm_consts.svh: offsets, field positions, control reset value, frame lengths, status bits
// assumes inclusion by the frame mapper top module and its testbench
// ============================================================
`ifndef DFBM_CONSTS_SVH
`define DFBM_CONSTS_SVH
// ============================================================
// frame layout
`define DFBM_SYNC_WORD 14'h3F0C
`define DFBM_SYNC_LEN 14
`define DFBM_HDR_LAST 15
`define DFBM_LOSD_POS 14
`define DFBM_SEGA_POS 15
`define DFBM_OH_LAST 9
`define DFBM_EOC_LEN 20
`define DFBM_CRC_POLY 6'h03
`define DFBM_GRP_LAST 2'h3
// ============================================================
// register offsets
`define DFBM_REG_CTRL 8'h00
`define DFBM_REG_TX_EOC 8'h04
`define DFBM_REG_RX_EOC 8'h08
`define DFBM_REG_RX_OH 8'h0C
`define DFBM_REG_STAT 8'h10
`define DFBM_REG_MASK 8'h14
// ============================================================
// control fields and reset value
`define DFBM_CTRL_N_MSB 5
`define DFBM_CTRL_N_LSB 0
`define DFBM_CTRL_I_MSB 8
`define DFBM_CTRL_I_LSB 6
`define DFBM_CTRL_CUST 9
`define DFBM_CTRL_SYNC 10
`define DFBM_CTRL_STUFF 11
`define DFBM_CTRL_LOSD 12
`define DFBM_CTRL_SEGA 13
`define DFBM_CTRL_SEGD 14
`define DFBM_CTRL_PS 15
`define DFBM_CTRL_RST 16'hF003
// ============================================================
// status bits
`define DFBM_ST_TX_START 0
`define DFBM_ST_RX_DONE 1
`define DFBM_ST_RX_CRC 2
`define DFBM_ST_RX_LOSS 3
`endif

// [verilog/dfbm_pkg.sv]
// dfbm_pkg.sv: types and overhead slot decoder of the frame mapper
// assumes the constants header alongside
package dfbm_pkg;
  // ============================================================
  // segment of the frame being walked
  typedef enum logic [3:0]
  {
    ST_HDR = 4'b0001,
    ST_PAY = 4'b0010,
    ST_OH = 4'b0100,
    ST_TAIL = 4'b1000
  } dfbm_seg_t;
  // kind of an overhead slot after a payload group
  typedef enum logic [2:0]
  {
    OH_EOC = 3'h0,
    OH_CRC = 3'h1,
    OH_PS = 3'h2,
    OH_SBID = 3'h3,
    OH_SEGD = 3'h4
  } dfbm_oh_t;
  // slot decode, group g follows payload group g-1
  function automatic dfbm_oh_t dfbm_oh_kind(input logic [1:0] g,
                                            input logic [3:0] o);
    dfbm_oh_t k;
    k = OH_EOC;
    if (o == 4'h4 || o == 4'h5)
      k = OH_CRC;
    else if (g == 2'h1 && o == 4'h6)
      k = OH_PS;
    else if ((g == 2'h1 && o == 4'h7) || (g == 2'h2 && o == 4'h9))
      k = OH_SBID;
    else if (g == 2'h2 && o == 4'h6)
      k = OH_SEGD;
    return k;
  endfunction : dfbm_oh_kind
endpackage : dfbm_pkg

// [verilog/dfbm_top.sv]
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "dfbm_consts.svh"
// dfbm_top.sv: data-mode frame assembler and parser with register port
// assumes one line bit per strobe, strobes at least two cycles apart
module dfbm_top
  import dfbm_pkg::*;
#(
  parameter int CNT_W = 12
)
(
  // clock, reset, enable
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  input wire logic CE_IN,
  // register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic IRQ_OUT,
  // transmit stream toward the scrambler
  input wire logic TX_BIT_STB_IN,
  input wire logic TX_PAY_IN,
  output logic TX_BIT_OUT,
  output logic TX_PAY_TAKE_OUT,
  // receive stream from the descrambler
  input wire logic RX_BIT_STB_IN,
  input wire logic RX_BIT_IN,
  output logic RX_PAY_OUT,
  output logic RX_PAY_VLD_OUT,
  output logic RX_LOCK_OUT
);
  // 12k reaches 3540, so narrower counters would wrap
  if (CNT_W < 12)
  begin : g_bad_cnt
    $error("CNT_W below 12 cannot hold a payload group");
  end

  // ============================================================
  // state
  logic [15:0] ctrl_q, ctrl_d;
  logic [19:0] tx_eoc_q, tx_eoc_d, rx_eoc_q, rx_eoc_d;
  logic [3:0] stat_q, stat_d, mask_q, mask_d, rx_oh_q, rx_oh_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  dfbm_seg_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [CNT_W-1:0] tx_offs_q, tx_offs_d, rx_offs_q, rx_offs_d;
  logic [1:0] tx_grp_q, tx_grp_d, rx_grp_q, rx_grp_d;
  logic [19:0] tx_esh_q, tx_esh_d, rx_esh_q, rx_esh_d;
  logic [5:0] tx_crun_q, tx_crun_d, tx_csnd_q, tx_csnd_d;
  logic [5:0] rx_crun_q, rx_crun_d, rx_cexp_q, rx_cexp_d;
  logic [5:0] rx_cgot_q, rx_cgot_d;
  logic tx_stuff_q, tx_stuff_d, rx_stuff_q, rx_stuff_d;
  logic rx_sb1_q, rx_sb1_d, rx_prev_q, rx_prev_d;
  logic rx_lock_q, rx_lock_d;
  logic [13:0] rx_sh_q, rx_sh_d;
  logic tx_bit_q, tx_bit_d, tx_take_q, tx_take_d;
  logic rx_pay_q, rx_pay_d, rx_vld_q, rx_vld_d;
  logic tx_evt, rx_done_evt, rx_crc_evt, rx_loss_evt;

  // ============================================================
  // configuration decode
  logic [8:0] blk_k;
  logic [CNT_W-1:0] pay_last;
  logic [13:0] sync_word;
  logic cfg_cust, cfg_sync;
  assign cfg_cust = ctrl_q[`DFBM_CTRL_CUST];
  assign cfg_sync = ctrl_q[`DFBM_CTRL_SYNC];
  assign sync_word = `DFBM_SYNC_WORD;
  // block length from B-channel and Z-bit counts
  assign blk_k = {ctrl_q[`DFBM_CTRL_N_MSB:`DFBM_CTRL_N_LSB], 3'h0}
               + {6'h00, ctrl_q[`DFBM_CTRL_I_MSB:`DFBM_CTRL_I_LSB]};
  assign pay_last = CNT_W'({blk_k, 3'h0} + {1'b0, blk_k, 2'h0} - 12'h001);

  // serial crc-6 step, msb first
  function automatic logic [5:0] crc_step(input logic [5:0] c,
                                          input logic b);
    logic fb;
    fb = b ^ c[5];
    return {c[4:0], 1'b0} ^ ({6{fb}} & `DFBM_CRC_POLY);
  endfunction : crc_step

  // ============================================================
  // transmit assembly, next values
  always_comb
  begin
    logic b;
    logic use_crc;
    b = 1'b1;
    use_crc = 1'b0;
    tx_evt = 1'b0;
    tx_st_d = tx_st_q;
    tx_offs_d = tx_offs_q;
    tx_grp_d = tx_grp_q;
    tx_esh_d = tx_esh_q;
    tx_crun_d = tx_crun_q;
    tx_csnd_d = tx_csnd_q;
    tx_stuff_d = tx_stuff_q;
    tx_bit_d = tx_bit_q;
    tx_take_d = 1'b0;
    if (CE_IN && TX_BIT_STB_IN)
    begin
      tx_offs_d = tx_offs_q + 1'b1;
      unique case (tx_st_q)
        ST_HDR:
        begin
          if (tx_offs_q == '0)
          begin
            // last frame's check goes out in this one
            tx_csnd_d = tx_crun_q;
            tx_crun_d = '0;
            tx_esh_d = tx_eoc_q;
            tx_stuff_d = ctrl_q[`DFBM_CTRL_STUFF] & ~cfg_sync;
            tx_evt = 1'b1;
          end
          if (tx_offs_q < `DFBM_SYNC_LEN)
            b = sync_word[4'(`DFBM_SYNC_LEN - 1) - tx_offs_q[3:0]];
          else if (tx_offs_q == `DFBM_LOSD_POS)
            b = ctrl_q[`DFBM_CTRL_LOSD];
          else
            b = ctrl_q[`DFBM_CTRL_SEGA];
          use_crc = (tx_offs_q >= `DFBM_SYNC_LEN);
          if (tx_offs_q == `DFBM_HDR_LAST)
          begin
            tx_st_d = ST_PAY;
            tx_offs_d = '0;
            tx_grp_d = 2'h0;
          end
        end
        ST_PAY:
        begin
          b = TX_PAY_IN;
          tx_take_d = 1'b1;
          use_crc = 1'b1;
          if (tx_offs_q == pay_last)
          begin
            tx_offs_d = '0;
            tx_grp_d = tx_grp_q + 2'h1;
            if (tx_grp_q != `DFBM_GRP_LAST)
              tx_st_d = ST_OH;
            else
              tx_st_d = (cfg_sync || tx_stuff_q) ? ST_TAIL : ST_HDR;
          end
        end
        ST_OH:
        begin
          use_crc = 1'b1;
          unique case (dfbm_oh_kind(tx_grp_q, tx_offs_q[3:0]))
            OH_EOC:
            begin
              b = tx_esh_q[19];
              tx_esh_d = {tx_esh_q[18:0], 1'b1};
            end
            OH_CRC:
            begin
              b = tx_csnd_q[5];
              tx_csnd_d = {tx_csnd_q[4:0], 1'b1};
              use_crc = 1'b0;
            end
            // upstream only; downstream the slot idles at one
            OH_PS: b = cfg_cust ? ctrl_q[`DFBM_CTRL_PS] : 1'b1;
            OH_SBID: b = cfg_sync | tx_stuff_q;
            OH_SEGD: b = ctrl_q[`DFBM_CTRL_SEGD];
          endcase
          if (tx_offs_q == `DFBM_OH_LAST)
          begin
            tx_st_d = ST_PAY;
            tx_offs_d = '0;
          end
        end
        ST_TAIL:
        begin
          // stuff bits and spares both idle at one
          b = 1'b1;
          use_crc = cfg_sync;
          if (tx_offs_q == (cfg_sync ? CNT_W'(1) : CNT_W'(3)))
          begin
            tx_st_d = ST_HDR;
            tx_offs_d = '0;
          end
        end
      endcase
      tx_bit_d = b;
      if (use_crc)
        tx_crun_d = crc_step(tx_crun_d, b);
    end
  end

  // ============================================================
  // receive parse, next values
  always_comb
  begin
    logic b;
    logic use_crc;
    logic fend;
    b = RX_BIT_IN;
    use_crc = 1'b0;
    fend = 1'b0;
    rx_done_evt = 1'b0;
    rx_crc_evt = 1'b0;
    rx_loss_evt = 1'b0;
    rx_st_d = rx_st_q;
    rx_offs_d = rx_offs_q;
    rx_grp_d = rx_grp_q;
    rx_sh_d = rx_sh_q;
    rx_lock_d = rx_lock_q;
    rx_esh_d = rx_esh_q;
    rx_eoc_d = rx_eoc_q;
    rx_oh_d = rx_oh_q;
    rx_crun_d = rx_crun_q;
    rx_cexp_d = rx_cexp_q;
    rx_cgot_d = rx_cgot_q;
    rx_stuff_d = rx_stuff_q;
    rx_sb1_d = rx_sb1_q;
    rx_prev_d = rx_prev_q;
    rx_pay_d = rx_pay_q;
    rx_vld_d = 1'b0;
    if (CE_IN && RX_BIT_STB_IN)
    begin
      rx_sh_d = {rx_sh_q[12:0], b};
      rx_offs_d = rx_offs_q + 1'b1;
      if (!rx_lock_q)
      begin
        // hunt: the sync word marks where the header starts
        if (rx_sh_d == sync_word)
        begin
          rx_lock_d = 1'b1;
          rx_st_d = ST_HDR;
          rx_offs_d = CNT_W'(`DFBM_SYNC_LEN);
          rx_crun_d = '0;
          rx_prev_d = 1'b0;
        end
      end
      else
      begin
        unique case (rx_st_q)
          ST_HDR:
          begin
            if (rx_offs_q == CNT_W'(`DFBM_SYNC_LEN - 1) &&
                rx_sh_d != sync_word)
            begin
              rx_lock_d = 1'b0;
              rx_loss_evt = 1'b1;
            end
            if (rx_offs_q == `DFBM_LOSD_POS)
              rx_oh_d[0] = b;
            if (rx_offs_q == `DFBM_SEGA_POS)
            begin
              rx_oh_d[1] = b;
              rx_st_d = ST_PAY;
              rx_offs_d = '0;
              rx_grp_d = 2'h0;
            end
            use_crc = (rx_offs_q >= `DFBM_SYNC_LEN);
          end
          ST_PAY:
          begin
            rx_pay_d = b;
            rx_vld_d = 1'b1;
            use_crc = 1'b1;
            if (rx_offs_q == pay_last)
            begin
              rx_offs_d = '0;
              rx_grp_d = rx_grp_q + 2'h1;
              fend = (rx_grp_q == `DFBM_GRP_LAST) && !cfg_sync &&
                     !rx_stuff_q;
              if (rx_grp_q != `DFBM_GRP_LAST)
                rx_st_d = ST_OH;
              else
                rx_st_d = fend ? ST_HDR : ST_TAIL;
            end
          end
          ST_OH:
          begin
            use_crc = 1'b1;
            unique case (dfbm_oh_kind(rx_grp_q, rx_offs_q[3:0]))
              OH_EOC: rx_esh_d = {rx_esh_q[18:0], b};
              OH_CRC:
              begin
                rx_cgot_d = {rx_cgot_q[4:0], b};
                use_crc = 1'b0;
              end
              // power status only meaningful from the customer side
              OH_PS: rx_oh_d[3] = cfg_cust | b;
              OH_SBID:
              begin
                rx_sb1_d = b;
                if (rx_grp_q == 2'h2)
                  rx_stuff_d = rx_sb1_q & b & ~cfg_sync;
              end
              OH_SEGD: rx_oh_d[2] = b;
            endcase
            if (rx_offs_q == `DFBM_OH_LAST)
            begin
              rx_st_d = ST_PAY;
              rx_offs_d = '0;
            end
          end
          ST_TAIL:
          begin
            use_crc = cfg_sync;
            if (rx_offs_q == (cfg_sync ? CNT_W'(1) : CNT_W'(3)))
            begin
              fend = 1'b1;
              rx_st_d = ST_HDR;
            end
          end
        endcase
        if (use_crc)
          rx_crun_d = crc_step(rx_crun_q, b);
        if (fend)
        begin
          // check this frame's crc against the one computed before
          rx_offs_d = '0;
          rx_eoc_d = rx_esh_d;
          rx_done_evt = 1'b1;
          rx_crc_evt = rx_prev_q && (rx_cgot_d != rx_cexp_q);
          rx_cexp_d = rx_crun_d;
          rx_crun_d = '0;
          rx_prev_d = 1'b1;
          rx_stuff_d = 1'b0;
        end
      end
    end
  end

  // ============================================================
  // register port and interrupt, next values
  always_comb
  begin
    logic [3:0] evts;
    evts = {rx_loss_evt, rx_crc_evt, rx_done_evt, tx_evt};
    ctrl_d = ctrl_q;
    tx_eoc_d = tx_eoc_q;
    mask_d = mask_q;
    rdata_d = 32'h0000_0000;
    stat_d = stat_q;
    if (CE_IN && REG_WR_IN)
    begin
      unique case (REG_ADDR_IN)
        `DFBM_REG_CTRL: ctrl_d = REG_WDATA_IN[15:0];
        `DFBM_REG_TX_EOC: tx_eoc_d = REG_WDATA_IN[19:0];
        `DFBM_REG_MASK: mask_d = REG_WDATA_IN[3:0];
        default: ;
      endcase
    end
    if (CE_IN && REG_RD_IN)
    begin
      unique case (REG_ADDR_IN)
        `DFBM_REG_CTRL: rdata_d = {16'h0000, ctrl_q};
        `DFBM_REG_TX_EOC: rdata_d = {12'h000, tx_eoc_q};
        `DFBM_REG_RX_EOC: rdata_d = {12'h000, rx_eoc_q};
        `DFBM_REG_RX_OH: rdata_d = {27'h0000000, rx_lock_q, rx_oh_q};
        `DFBM_REG_STAT:
        begin
          rdata_d = {28'h0000000, stat_q};
          stat_d = 4'h0;
        end
        `DFBM_REG_MASK: rdata_d = {28'h0000000, mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    // a new event beats the read that clears it
    stat_d = stat_d | (CE_IN ? evts : 4'h0);
    irq_d = |(stat_d & mask_q);
  end

  // ============================================================
  // registers, frozen while the enable is low
  always_ff @(posedge MCLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ctrl_q <= `DFBM_CTRL_RST;
      tx_eoc_q <= 20'hFFFFF;
      rx_eoc_q <= 20'hFFFFF;
      stat_q <= 4'h0;
      mask_q <= 4'h0;
      rx_oh_q <= 4'hF;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
      tx_st_q <= ST_HDR;
      rx_st_q <= ST_HDR;
      tx_offs_q <= '0;
      rx_offs_q <= '0;
      tx_grp_q <= 2'h0;
      rx_grp_q <= 2'h0;
      tx_esh_q <= 20'hFFFFF;
      rx_esh_q <= 20'hFFFFF;
      tx_crun_q <= 6'h00;
      tx_csnd_q <= 6'h3F;
      rx_crun_q <= 6'h00;
      rx_cexp_q <= 6'h00;
      rx_cgot_q <= 6'h00;
      tx_stuff_q <= 1'b0;
      rx_stuff_q <= 1'b0;
      rx_sb1_q <= 1'b0;
      rx_prev_q <= 1'b0;
      rx_lock_q <= 1'b0;
      rx_sh_q <= 14'h0000;
      tx_bit_q <= 1'b1;
      tx_take_q <= 1'b0;
      rx_pay_q <= 1'b0;
      rx_vld_q <= 1'b0;
    end
    else if (CE_IN)
    begin
      ctrl_q <= ctrl_d;
      tx_eoc_q <= tx_eoc_d;
      rx_eoc_q <= rx_eoc_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rx_oh_q <= rx_oh_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      tx_st_q <= tx_st_d;
      rx_st_q <= rx_st_d;
      tx_offs_q <= tx_offs_d;
      rx_offs_q <= rx_offs_d;
      tx_grp_q <= tx_grp_d;
      rx_grp_q <= rx_grp_d;
      tx_esh_q <= tx_esh_d;
      rx_esh_q <= rx_esh_d;
      tx_crun_q <= tx_crun_d;
      tx_csnd_q <= tx_csnd_d;
      rx_crun_q <= rx_crun_d;
      rx_cexp_q <= rx_cexp_d;
      rx_cgot_q <= rx_cgot_d;
      tx_stuff_q <= tx_stuff_d;
      rx_stuff_q <= rx_stuff_d;
      rx_sb1_q <= rx_sb1_d;
      rx_prev_q <= rx_prev_d;
      rx_lock_q <= rx_lock_d;
      rx_sh_q <= rx_sh_d;
      tx_bit_q <= tx_bit_d;
      tx_take_q <= tx_take_d;
      rx_pay_q <= rx_pay_d;
      rx_vld_q <= rx_vld_d;
    end
  end

  assign REG_RDATA_OUT = rdata_q;
  assign IRQ_OUT = irq_q;
  assign TX_BIT_OUT = tx_bit_q;
  assign TX_PAY_TAKE_OUT = tx_take_q;
  assign RX_PAY_OUT = rx_pay_q;
  assign RX_PAY_VLD_OUT = rx_vld_q;
  assign RX_LOCK_OUT = rx_lock_q;

  // ============================================================
  // checks
  logic tx_stb;
  assign tx_stb = CE_IN && TX_BIT_STB_IN;
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);
  property p_tx_sync;
    tx_stb && tx_st_q == ST_HDR && tx_offs_q == '0 |=> TX_BIT_OUT;
  endproperty
  a_tx_sync: assert property (p_tx_sync) else $error("sync bit 1 wrong");
  property p_unassigned_one;
    tx_stb && tx_st_q == ST_OH && !cfg_cust && tx_grp_q == 2'h1 &&
      tx_offs_q == CNT_W'(6) |=> TX_BIT_OUT;
  endproperty
  a_unassigned_one: assert property (p_unassigned_one)
    else $error("unassigned slot not one");
  property p_take_pay;
    tx_stb && tx_st_q == ST_PAY |=>
      TX_PAY_TAKE_OUT && TX_BIT_OUT == $past(TX_PAY_IN);
  endproperty
  a_take_pay: assert property (p_take_pay) else $error("payload lost");
  property p_no_take;
    tx_stb && tx_st_q != ST_PAY |=> !TX_PAY_TAKE_OUT;
  endproperty
  a_no_take: assert property (p_no_take) else $error("stray take");
  property p_pay_len;
    tx_stb && tx_st_q == ST_PAY && tx_offs_q == pay_last |=> tx_st_q != ST_PAY;
  endproperty
  a_pay_len: assert property (p_pay_len) else $error("group length");
  property p_losd;
    tx_stb && tx_st_q == ST_HDR && tx_offs_q == CNT_W'(14) |=>
      TX_BIT_OUT == $past(ctrl_q[`DFBM_CTRL_LOSD]) ##0 tx_st_q == ST_HDR;
  endproperty
  a_losd: assert property (p_losd) else $error("loss bit wrong");
  property p_sega;
    tx_stb && tx_st_q == ST_HDR && tx_offs_q == CNT_W'(15) |=>
      TX_BIT_OUT == $past(ctrl_q[`DFBM_CTRL_SEGA]) && tx_st_q == ST_PAY;
  endproperty
  a_sega: assert property (p_sega) else $error("anomaly bit wrong");
  property p_sbid;
    tx_stb && tx_st_q == ST_OH && !cfg_sync && tx_grp_q == 2'h2 &&
      tx_offs_q == CNT_W'(9) |=> TX_BIT_OUT == $past(tx_stuff_q);
  endproperty
  a_sbid: assert property (p_sbid) else $error("stuff flag wrong");
  property p_tail;
    tx_st_q == ST_TAIL && cfg_sync |-> tx_offs_q < CNT_W'(2);
  endproperty
  a_tail: assert property (p_tail) else $error("spare tail long");
  c_tx_stuff: cover property (tx_stb && tx_st_q == ST_TAIL && tx_stuff_q);
  c_rx_lock: cover property (!rx_lock_q ##1 rx_lock_q);
  c_rx_crc: cover property (rx_crc_evt);
  c_irq: cover property (!IRQ_OUT ##1 IRQ_OUT);
endmodule : dfbm_top

// [dv/dfbm_peer_model.sv]
// dfbm_peer_model.sv: peer transceiver that echoes our line bits back
// assumes the mapper wants one bit strobe every second cycle at most
`timescale 1ns/1ps
module dfbm_peer_model
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // line side
  input wire logic run_in,
  input wire logic line_in,
  output logic tx_stb_out,
  output logic rx_stb_out,
  output logic rx_bit_out
);
  logic tx_stb_d;
  logic tx_stb_q;
  logic rx_stb_d;
  logic rx_stb_q;
  // ==========================================================
  // strobes: transmit every second cycle, receive one cycle later
  always_comb
  begin
    tx_stb_d = run_in & ~tx_stb_q;
    rx_stb_d = tx_stb_q;
  end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_stb_q <= 1'b0;
      rx_stb_q <= 1'b0;
    end
    else
    begin
      tx_stb_q <= tx_stb_d;
      rx_stb_q <= rx_stb_d;
    end
  end
  assign tx_stb_out = tx_stb_q;
  assign rx_stb_out = rx_stb_q;
  // same layout both ways, so our frame comes back unchanged
  // off-strobe the line shows the inverse, never a stale bit
  assign rx_bit_out = rx_stb_q ? line_in : ~line_in;
endmodule : dfbm_peer_model

// [dv/testbench.sv]
// testbench.sv: frame layout, receive path and register checks
// assumes n=3, i=0 so k=24, and the peer model echoing the line
`timescale 1ns/1ps
`include "dfbm_consts.svh"
module testbench;
  import dfbm_pkg::*;
  localparam int K = 24;
  localparam int NB = 3614;
  localparam logic [13:0] SYNC = 14'h3F0C;
  localparam logic [19:0] EOC = 20'hA5C3E;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run = 1'b0;
  logic pay = 1'b0;
  logic [31:0] rdata;
  logic irq, tx_stb, tx_bit, take, rx_stb, rx_bit, rx_pay, vld, lock;
  logic line [1:NB+4];
  int nbits = 0, ntake = 0, nvld = 0, npay1 = 0, cyc = 0;
  int miscompares = 0, check_count = 0;
  always #2 mclk = ~mclk;
  dfbm_top dfbm_top_inst(.MCLK_IN(mclk), .RESETN_IN(resetn),
    .CE_IN(1'b1), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .IRQ_OUT(irq), .TX_BIT_STB_IN(tx_stb), .TX_PAY_IN(pay),
    .TX_BIT_OUT(tx_bit), .TX_PAY_TAKE_OUT(take),
    .RX_BIT_STB_IN(rx_stb), .RX_BIT_IN(rx_bit), .RX_PAY_OUT(rx_pay),
    .RX_PAY_VLD_OUT(vld), .RX_LOCK_OUT(lock));
  dfbm_peer_model dfbm_peer_model_inst(.clk_in(mclk),
    .rst_n_in(resetn), .run_in(run), .line_in(tx_bit),
    .tx_stb_out(tx_stb), .rx_stb_out(rx_stb), .rx_bit_out(rx_bit));
  // ==========================================================
  // monitors: pre-edge values only, so no race with the design
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (rx_stb && nbits < NB + 4)
    begin
      line[nbits + 1] <= rx_bit;
      nbits <= nbits + 1;
    end
    if (take === 1'b1)
    begin
      // alternating payload, next bit ready before the next strobe
      ntake <= ntake + 1;
      pay <= ~pay;
    end
    if (vld === 1'b1)
      nvld <= nvld + 1;
    if (vld === 1'b1 && rx_pay !== 1'b0)
      npay1 <= npay1 + 1;
  end
  // hang guard, a full run needs about 7500 cycles
  always @(posedge mclk)
  begin
    if (cyc == 10000)
    begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  // expected bit {care, value} at frame position p
  function automatic logic [1:0] exp_bit(input int p, input logic st,
                                         input logic first,
                                         input logic ps);
    int s;
    int e;
    if (p <= 14) return {1'b1, SYNC[14 - p]};
    if (p == 15) return 2'b10;
    if (p == 16) return 2'b11;
    if (p > 48 * K + 46) return 2'b11;
    for (int g = 1; g <= 3; g++)
    begin
      s = p - (12 * K * g + 10 * g + 6);
      if (s >= 1 && s <= 10)
      begin
        // only the first frame's check is known: all zero
        if (s == 5 || s == 6) return {first, 1'b0};
        if (g == 1 && s == 7) return {1'b1, ps};
        if ((g == 1 && s == 8) || (g == 2 && s == 10)) return {1'b1, st};
        if (g == 2 && s == 7) return 2'b10;
        e = 6 * (g - 1) + s - ((s > 4) ? 5 - g : 0);
        return {1'b1, EOC[20 - e]};
      end
    end
    // payload alternates from zero, so odd positions carry zero
    return {1'b1, ~p[0]};
  endfunction : exp_bit
  // ==========================================================
  // scenarios
  task automatic t_reset_regs();
    logic [31:0] d;
    reg_rd(`DFBM_REG_CTRL, d);
    chk(d, {16'h0, `DFBM_CTRL_RST}, "ctrl reset");
    reg_rd(`DFBM_REG_TX_EOC, d);
    chk(d, 32'h000FFFFF, "tx eoc reset");
    reg_rd(`DFBM_REG_MASK, d);
    chk(d, 32'h0, "mask reset");
    reg_wr(8'h18, 32'hFFFFFFFF);
    reg_rd(8'h18, d);
    chk(d, 32'h0, "unmapped");
  endtask : t_reset_regs
  // frame 1 stuffed, frame 2 plain, frame 3 synchronous from the
  // customer side with power failed, then the sync word of frame 4
  task automatic t_frames();
    logic [1:0] e2;
    logic [5:0] cr;
    logic [5:0] e6;
    reg_wr(`DFBM_REG_MASK, 32'h2);
    reg_wr(`DFBM_REG_TX_EOC, {12'h0, EOC});
    reg_wr(`DFBM_REG_CTRL, 32'h0000A803);
    run <= 1'b1;
    for (int c = 0; c < 400 && nbits < 100; c++) @(posedge mclk);
    reg_wr(`DFBM_REG_CTRL, 32'h0000A003);
    for (int c = 0; c < 6000 && nbits < 2420; c++) @(posedge mclk);
    // lands in frame 3's first payload group, ahead of its ps slot
    reg_wr(`DFBM_REG_CTRL, 32'h00002603);
    for (int c = 0; c < 3000 && nbits < NB; c++) @(posedge mclk);
    run <= 1'b0;
    repeat (8) @(posedge mclk);
    for (int p = 1; p <= NB; p++)
    begin
      if (p <= 1202)
        e2 = exp_bit(p, 1'b1, 1'b1, 1'b1);
      else if (p <= 2400)
        e2 = exp_bit(p - 1202, 1'b0, 1'b0, 1'b1);
      else if (p <= 3600)
        e2 = exp_bit(p - 2400, 1'b1, 1'b0, 1'b0);
      else
        e2 = exp_bit(p - 3600, 1'b1, 1'b0, 1'b0);
      if (e2[1])
        chk({31'h0, line[p]}, {31'h0, e2[0]}, $sformatf("bit %0d", p));
    end
    // crc-6 of frame 1 from the echo, sync, crc and stuff left out
    cr = 6'h00;
    for (int p = 15; p <= 48 * K + 46; p++)
      if ((p - 11) % (12 * K + 10) > 1)
        cr = {cr[4:0], 1'b0} ^ {4'h0, {2{line[p] ^ cr[5]}}};
    e6 = 6'h00;
    for (int g = 1; g <= 3; g++)
      e6 = {e6[3:0], line[1213 + g * (12 * K + 10)],
            line[1214 + g * (12 * K + 10)]};
    chk({26'h0, e6}, {26'h0, cr}, "crc of frame 1");
    chk(ntake, 3 * 48 * K, "tx takes");
    chk(nvld, 3 * 48 * K, "rx payload count");
    chk(npay1, 3 * 24 * K, "rx payload ones");
  endtask : t_frames
  task automatic t_rx_status();
    logic [31:0] d;
    chk({31'h0, lock}, 32'h1, "lock");
    chk({31'h0, irq}, 32'h1, "irq set");
    reg_rd(`DFBM_REG_STAT, d);
    chk(d, 32'h3, "status");
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "irq clear");
    reg_rd(`DFBM_REG_RX_OH, d);
    chk(d & 32'h1F, 32'h1A, "rx overhead");
    reg_rd(`DFBM_REG_RX_EOC, d);
    chk(d, {12'h0, EOC}, "rx eoc");
  endtask : t_rx_status
  // ==========================================================
  // verdict
  task automatic end_sim();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    t_reset_regs();
    t_frames();
    t_rx_status();
    end_sim();
  end
endmodule : testbench
